// ===== blc_black_level_autocal.v
`timescale 1ns/1ps
`include "blc_defs.vh"

// Function
// - a falling black clamp pulse starts one calibration pass
// - average black samples per line, compare with target, steer fine DAC
// - offset beyond fine span of 255 LSB uses coarse and fine together
// - coarse DAC moves one step per pass toward fine range
// - one fine DAC step equals one converter LSB
// - coarse step is gain times n LSB, n from gain code bands
// - coarse DAC drives ahead of gain stage, fine DAC after it
// - loop settles residual error to within one LSB
// - calibrated output equals input times gain plus target level
// - rolling average weight programmable down to 1/256, larger converges faster
// - samples outside hot or cold limits replaced by preceding sample, the first of a line by the filtered black level
// - fast mode: first frame line ignores limits and uses weight one
// - black samples per line are two to the N, N 0 to 6
// - returning to auto mode starts from the held DAC values
// - gain code limited to 0 to 767
module blc_black_level_autocal #(
  parameter DW = 10,
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          black_clamp_pulse_n,
  input  wire          frame_start,
  input  wire [DW-1:0] adc_data,
  output reg  [7:0]    coarse_offset_dac,
  output reg  [8:0]    fine_offset_dac
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_IDLE   = 4'b0001;
  localparam [3:0] ST_SAMPLE = 4'b0010;
  localparam [3:0] ST_FILTER = 4'b0100;
  localparam [3:0] ST_UPDATE = 4'b1000;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function is_mapped;
    input [AW-1:0] a;
    begin
      is_mapped = (a[1:0] == 2'h0) && (a <= `BLC_OFS_STATUS);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  function [7:0] coarse_lsb;
    input [9:0] g;
    reg   [2:0] n;
    reg   [9:0] oct;
    begin
      if (g < `BLC_GAIN_N3) begin
        n = 3'h4;
      end else if (g < `BLC_GAIN_N2) begin
        n = 3'h3;
      end else if (g < `BLC_GAIN_N1) begin
        n = 3'h2;
      end else begin
        n = 3'h1;
      end
      // linear gain doubles about every 6 dB; a power-of-two estimate is enough
      oct = g / `BLC_CODES_OCTAVE;
      coarse_lsb = {5'h00, n} << oct[2:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers: level moves once stages two and three agree
  // ----------------------------------------------------------------------
  reg  [2:0] clamp_sync;
  reg  [2:0] frame_sync;
  reg        clamp_lvl;
  reg        frame_lvl;
  reg        clamp_lvl_d;
  reg        frame_lvl_d;
  wire       clamp_fall;
  wire       clamp_rise;
  wire       frame_rise;

  always @(posedge aclk) begin
    if (!aresetn) begin
      clamp_sync  <= 3'h7;
      frame_sync  <= 3'h0;
      clamp_lvl   <= 1'b1;
      frame_lvl   <= 1'b0;
      clamp_lvl_d <= 1'b1;
      frame_lvl_d <= 1'b0;
    end else begin
      clamp_sync  <= {clamp_sync[1:0], black_clamp_pulse_n};
      frame_sync  <= {frame_sync[1:0], frame_start};
      if (clamp_sync[1] == clamp_sync[2]) begin
        clamp_lvl <= clamp_sync[2];
      end
      if (frame_sync[1] == frame_sync[2]) begin
        frame_lvl <= frame_sync[2];
      end
      clamp_lvl_d <= clamp_lvl;
      frame_lvl_d <= frame_lvl;
    end
  end

  assign clamp_fall = clamp_lvl_d && !clamp_lvl;
  assign clamp_rise = !clamp_lvl_d && clamp_lvl;
  assign frame_rise = !frame_lvl_d && frame_lvl;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg          auto_en;
  reg          fast_en;
  reg  [2:0]   n_exp;
  reg  [DW-1:0] target_black_level;
  reg  [3:0]   weight_shift;
  reg  [DW-1:0] hot_limit;
  reg  [DW-1:0] cold_limit;
  reg  [9:0]   gain_code;
  reg  [3:0]   state;
  reg          first_line;
  reg          locked;
  reg  [17:0]  filt_q;

  reg          aw_full;
  reg          w_full;
  reg  [AW-1:0] aw_addr;
  reg  [31:0]  w_data;
  reg  [3:0]   w_strb;
  reg  [31:0]  next_rdata;
  wire         do_write;
  wire [31:0]  wv;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= {AW{1'b0}};
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BLC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `BLC_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? `BLC_RESP_OKAY : `BLC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `BLC_RESP_OKAY : `BLC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (s_axi_araddr == `BLC_OFS_CTRL) begin
      next_rdata[`BLC_CTRL_AUTO] = auto_en;
      next_rdata[`BLC_CTRL_FAST] = fast_en;
      next_rdata[`BLC_CTRL_NHI:`BLC_CTRL_NLO] = n_exp;
    end else if (s_axi_araddr == `BLC_OFS_TARGET) begin
      next_rdata[DW-1:0] = target_black_level;
    end else if (s_axi_araddr == `BLC_OFS_WEIGHT) begin
      next_rdata[3:0] = weight_shift;
    end else if (s_axi_araddr == `BLC_OFS_HOT) begin
      next_rdata[DW-1:0] = hot_limit;
    end else if (s_axi_araddr == `BLC_OFS_COLD) begin
      next_rdata[DW-1:0] = cold_limit;
    end else if (s_axi_araddr == `BLC_OFS_GAIN) begin
      next_rdata[9:0] = gain_code;
    end else if (s_axi_araddr == `BLC_OFS_FINE) begin
      next_rdata[8:0] = fine_offset_dac;
    end else if (s_axi_araddr == `BLC_OFS_COARSE) begin
      next_rdata[7:0] = coarse_offset_dac;
    end else if (s_axi_araddr == `BLC_OFS_STATUS) begin
      next_rdata[9:0]             = filt_q[17:8];
      next_rdata[`BLC_STAT_BUSY]  = !state[0];
      next_rdata[`BLC_STAT_LOCK]  = locked;
      next_rdata[`BLC_STAT_FIRST] = first_line;
    end
  end

  // ----------------------------------------------------------------------
  // averager
  // ----------------------------------------------------------------------
  wire [DW-1:0] line_avg;
  wire          line_full;
  wire          limits_off;

  assign limits_off = fast_en && first_line;

  blc_black_avg #(
    .DW (DW)
  ) u_avg (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (state[0] && clamp_fall),
    .sample_en  (state[1] && !clamp_lvl),
    .adc_data   (adc_data),
    .hot_limit  (hot_limit),
    .cold_limit (cold_limit),
    .limits_off (limits_off),
    .n_exp      (n_exp),
    .prev_seed  (filt_q[17:8]),
    .avg        (line_avg),
    .full       (line_full)
  );

  // ----------------------------------------------------------------------
  // loop arithmetic
  // ----------------------------------------------------------------------
  wire        [3:0]  k_eff;
  wire signed [18:0] diff;
  wire signed [18:0] diff_w;
  wire signed [11:0] err;
  wire signed [11:0] fine_want;
  wire signed [11:0] step;
  wire               over_hi;
  wire               over_lo;
  wire signed [11:0] fine_res;
  wire signed [11:0] fine_sat;

  // weight is 1/2^k, k up to 8
  assign k_eff  = limits_off ? 4'h0 : weight_shift;
  assign diff   = $signed({1'b0, line_avg, 8'h00}) - $signed({1'b0, filt_q});
  assign diff_w = diff >>> k_eff;

  assign err       = $signed({2'b00, filt_q[17:8]}) - $signed({2'b00, target_black_level});
  assign fine_want = $signed({{3{fine_offset_dac[8]}}, fine_offset_dac}) - err;
  assign step      = $signed({4'h0, coarse_lsb(gain_code)});
  assign over_hi   = fine_want > $signed(`BLC_FINE_SPAN) && coarse_offset_dac != `BLC_COARSE_MAX;
  assign over_lo   = fine_want < -$signed(`BLC_FINE_SPAN) && coarse_offset_dac != `BLC_COARSE_MIN;
  assign fine_res  = over_hi ? fine_want - step : (over_lo ? fine_want + step : fine_want);
  assign fine_sat  = (fine_res > $signed(`BLC_FINE_SPAN)) ? $signed(`BLC_FINE_SPAN) :
                     ((fine_res < -$signed(`BLC_FINE_SPAN)) ? -$signed(`BLC_FINE_SPAN) :
                     fine_res);

  // ----------------------------------------------------------------------
  // control registers, sequencer and DACs
  // ----------------------------------------------------------------------
  assign wv = merge(32'h00000000, w_data, w_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      auto_en            <= `BLC_RST_AUTO;
      fast_en            <= `BLC_RST_FAST;
      n_exp              <= `BLC_RST_NEXP;
      target_black_level <= `BLC_RST_TARGET;
      weight_shift       <= `BLC_RST_WEIGHT;
      hot_limit          <= `BLC_RST_HOT;
      cold_limit         <= `BLC_RST_COLD;
      gain_code          <= `BLC_RST_GAIN;
      fine_offset_dac    <= 9'h000;
      coarse_offset_dac  <= 8'h00;
      state              <= ST_IDLE;
      first_line         <= 1'b0;
      locked             <= 1'b0;
      filt_q             <= {`BLC_RST_TARGET, 8'h00};
    end else begin
      case (state)
        ST_IDLE: begin
          if (clamp_fall) begin
            state <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (clamp_rise) begin
            state <= line_full ? ST_FILTER : ST_IDLE;
          end
        end
        ST_FILTER: begin
          filt_q <= filt_q + diff_w[17:0];
          state  <= ST_UPDATE;
        end
        ST_UPDATE: begin
          locked <= (err <= 12'sh001) && (err >= -12'sh001);
          // loop starts from held DAC values
          if (auto_en) begin
            if (over_hi) begin
              coarse_offset_dac <= coarse_offset_dac + 8'h01;
            end else if (over_lo) begin
              coarse_offset_dac <= coarse_offset_dac - 8'h01;
            end
            fine_offset_dac <= fine_sat[8:0];
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // first line of frame, set wins over clear
      if (frame_rise) begin
        first_line <= 1'b1;
      end else if (state[3]) begin
        first_line <= 1'b0;
      end
      if (do_write) begin
        if (aw_addr == `BLC_OFS_CTRL) begin
          auto_en <= wv[`BLC_CTRL_AUTO];
          fast_en <= wv[`BLC_CTRL_FAST];
          n_exp   <= (wv[`BLC_CTRL_NHI:`BLC_CTRL_NLO] > `BLC_NEXP_MAX) ?
                     `BLC_NEXP_MAX : wv[`BLC_CTRL_NHI:`BLC_CTRL_NLO];
        end else if (aw_addr == `BLC_OFS_TARGET) begin
          target_black_level <= wv[DW-1:0];
        end else if (aw_addr == `BLC_OFS_WEIGHT) begin
          weight_shift <= (wv[3:0] > `BLC_WEIGHT_MAX) ? `BLC_WEIGHT_MAX : wv[3:0];
        end else if (aw_addr == `BLC_OFS_HOT) begin
          hot_limit <= wv[DW-1:0];
        end else if (aw_addr == `BLC_OFS_COLD) begin
          cold_limit <= wv[DW-1:0];
        end else if (aw_addr == `BLC_OFS_GAIN) begin
          gain_code <= (wv[9:0] > `BLC_GAIN_MAX) ? `BLC_GAIN_MAX : wv[9:0];
        end else if (aw_addr == `BLC_OFS_FINE) begin
          fine_offset_dac <= wv[8:0];
        end else if (aw_addr == `BLC_OFS_COARSE) begin
          coarse_offset_dac <= wv[7:0];
        end
      end
    end
  end

endmodule

// ===== blc_defs.vh
`ifndef BLC_DEFS_VH
`define BLC_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BLC_OFS_CTRL     8'h00
`define BLC_OFS_TARGET   8'h04
`define BLC_OFS_WEIGHT   8'h08
`define BLC_OFS_HOT      8'h0C
`define BLC_OFS_COLD     8'h10
`define BLC_OFS_GAIN     8'h14
`define BLC_OFS_FINE     8'h18
`define BLC_OFS_COARSE   8'h1C
`define BLC_OFS_STATUS   8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BLC_CTRL_AUTO    0
`define BLC_CTRL_FAST    1
`define BLC_CTRL_NLO     2
`define BLC_CTRL_NHI     4
`define BLC_STAT_BUSY    16
`define BLC_STAT_LOCK    17
`define BLC_STAT_FIRST   18

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BLC_RST_AUTO     1'b1
`define BLC_RST_FAST     1'b0
`define BLC_RST_NEXP     3'h4
`define BLC_RST_TARGET   10'h040
`define BLC_RST_WEIGHT   4'h4
`define BLC_RST_HOT      10'h3FF
`define BLC_RST_COLD     10'h000
`define BLC_RST_GAIN     10'h000

// ----------------------------------------------------------------------
// limits and loop figures
// ----------------------------------------------------------------------
`define BLC_NEXP_MAX     3'h6
`define BLC_WEIGHT_MAX   4'h8
`define BLC_GAIN_MAX     10'h2FF
`define BLC_FINE_SPAN    12'h0FF
`define BLC_COARSE_MAX   8'h7F
`define BLC_COARSE_MIN   8'h81
`define BLC_GAIN_N3      10'h080
`define BLC_GAIN_N2      10'h0C0
`define BLC_GAIN_N1      10'h100
`define BLC_CODES_OCTAVE 10'h086

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define BLC_RESP_OKAY    2'h0
`define BLC_RESP_SLVERR  2'h2

`endif

// ===== blc_black_avg.v
`timescale 1ns/1ps
`include "blc_defs.vh"

// ----------------------------------------------------------------------
// per-line black sample averager with hot/cold pixel rejection
// ----------------------------------------------------------------------
module blc_black_avg #(
  parameter DW = 10
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          start,
  input  wire          sample_en,
  input  wire [DW-1:0] adc_data,
  input  wire [DW-1:0] hot_limit,
  input  wire [DW-1:0] cold_limit,
  input  wire          limits_off,
  input  wire [2:0]    n_exp,
  input  wire [DW-1:0] prev_seed,
  output reg  [DW-1:0] avg,
  output reg           full
);

  reg  [6:0]    cnt;
  reg  [15:0]   sum;
  reg  [DW-1:0] prev;
  wire [DW-1:0] pick;
  wire [15:0]   next_sum;
  wire [15:0]   next_avg;
  wire [6:0]    next_cnt;
  wire [6:0]    target_cnt;

  assign pick = (limits_off || (adc_data <= hot_limit && adc_data >= cold_limit)) ?
                adc_data : prev;
  assign next_sum = sum + {6'h00, pick};
  assign next_cnt = cnt + 7'h01;
  assign next_avg = next_sum >> n_exp;
  assign target_cnt = 7'h01 << n_exp;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 7'h00;
      sum  <= 16'h0000;
      prev <= {DW{1'b0}};
      avg  <= {DW{1'b0}};
      full <= 1'b0;
    end else if (start) begin
      cnt  <= 7'h00;
      sum  <= 16'h0000;
      prev <= prev_seed;
      full <= 1'b0;
    end else if (sample_en && !full) begin
      sum  <= next_sum;
      prev <= pick;
      cnt  <= next_cnt;
      avg  <= next_avg[DW-1:0];
      if (next_cnt == target_cnt) begin
        full <= 1'b1;
      end
    end
  end

endmodule

// ===== blc_asserts.sv
`timescale 1ns/1ps
`include "blc_defs.vh"
module blc_asserts #(
  parameter DW = 10,
  parameter AW = 8
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        black_clamp_pulse_n,
  input wire [7:0]  coarse_offset_dac,
  input wire [8:0]  fine_offset_dac
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");

  // ----------------------------------------------------------------------
  // offset dacs
  // ----------------------------------------------------------------------
  // updates wait for the clamp to end; a bus write moves the dac in the same cycle that bvalid rises
  a_dac_hold: assert property ((!black_clamp_pulse_n)[*8] ##0 !s_axi_bvalid
    |-> $stable(fine_offset_dac) && $stable(coarse_offset_dac))
    else $error("dac moved during clamp");
  a_fine_span: assert property (fine_offset_dac != 9'h100)
    else $error("fine dac outside span");
  a_coarse_span: assert property (coarse_offset_dac != 8'h80)
    else $error("coarse dac outside span");
  a_coarse_step: assert property ($changed(coarse_offset_dac) && !s_axi_bvalid
    |-> (coarse_offset_dac - $past(coarse_offset_dac)) inside {8'h01, 8'hFF})
    else $error("coarse dac jumped more than one step");

  c_fine_move: cover property ($changed(fine_offset_dac) && !s_axi_bvalid);
  c_coarse_move: cover property ($changed(coarse_offset_dac) && !s_axi_bvalid);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `BLC_RESP_SLVERR);
endmodule

// ===== blc_tgen_model.sv
`timescale 1ns/1ps
module blc_tgen_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       go,
  input  wire [7:0] nlow,
  input  wire [9:0] level,
  input  wire       spike,
  input  wire       sof,
  output reg        black_clamp_pulse_n,
  output reg        frame_start,
  output reg  [9:0] adc_data,
  output reg        busy
);
  reg  [8:0] cnt;
  wire       low = busy && cnt >= 9'h003 && cnt < {1'b0, nlow} + 9'h003;

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      cnt <= 9'h000;
      black_clamp_pulse_n <= 1'b1;
      frame_start <= 1'b0;
      adc_data <= 10'h155;
    end else begin
      if (go && !busy) begin
        busy <= 1'b1;
        cnt <= 9'h000;
        frame_start <= sof;
      end else if (busy) begin
        cnt <= cnt + 9'h001;
      end
      black_clamp_pulse_n <= !low;
      // outside black pixels the data toggles so stale samples never look valid
      adc_data <= low ? ((spike && cnt[0]) ? 10'h3FF : level) : ~adc_data;
      if (busy && cnt == {1'b0, nlow} + 9'h008) begin
        busy <= 1'b0;
        frame_start <= 1'b0;
      end
    end
  end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "blc_defs.vh"
module tb_top;
  logic        aclk, aresetn, go, sof, spike;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, nlow;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [9:0]  level;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         black_clamp_pulse_n, frame_start, mbusy;
  wire  [9:0]  adc_data;
  wire  [7:0]  coarse_offset_dac;
  wire  [8:0]  fine_offset_dac;
  int          failures = 0, comparisons = 0, seed = 99, f = 0, c = 0, lv, i;
  int          gains [8] = '{0, 127, 128, 191, 192, 255, 256, 767};
  logic [31:0] rst_val [8] = '{{`BLC_RST_NEXP, `BLC_RST_FAST, `BLC_RST_AUTO},
    `BLC_RST_TARGET, `BLC_RST_WEIGHT, `BLC_RST_HOT, `BLC_RST_COLD, `BLC_RST_GAIN, 0, 0};

  blc_black_level_autocal dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .black_clamp_pulse_n, .frame_start, .adc_data, .coarse_offset_dac,
    .fine_offset_dac
  );
  blc_tgen_model u_tgen (
    .aclk, .aresetn, .go, .nlow, .level, .spike, .sof, .black_clamp_pulse_n, .frame_start,
    .adc_data, .busy(mbusy)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ready is sampled at the falling edge, where it already equals its value at the next rise
  // configuration writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int  n;
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      if (s_axi_bvalid) begin
        chk(s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    chk(0, 1);
    results;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int  n;
    logic ta;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, exp);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    chk(0, 1);
    results;
  endtask

  // expected loop step; coarse step is n scaled by the octave of the gain code
  function automatic void calc(input int avg, input int tg, input int g);
    int fw, st;
    fw = f - (avg - tg);
    st = (g < 128 ? 4 : g < 192 ? 3 : g < 256 ? 2 : 1) << (g / 134);
    if (fw > 255) begin
      c = c + 1;
      fw = fw - st;
    end else if (fw < -255) begin
      c = c - 1;
      fw = fw + st;
    end
    f = fw > 255 ? 255 : (fw < -255 ? -255 : fw);
  endfunction

  // one line of black pixels; g below zero means the dacs must not move
  task automatic line(input int lvl, nl, input logic sp, sf, input int avg, tg, g);
    int n;
    @(posedge aclk);
    level <= lvl[9:0];
    nlow <= nl[7:0];
    spike <= sp;
    sof <= sf;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (mbusy !== 1'b0 && n < 400);
    if (n == 400) begin
      chk(0, 1);
      results;
    end
    repeat (12) @(posedge aclk);
    if (g >= 0) calc(avg, tg, g);
    chk(fine_offset_dac, f[8:0]);
    chk(coarse_offset_dac, c[7:0]);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {aresetn, go, sof, spike, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, nlow, level, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(8'h06, 32'h155, `BLC_RESP_SLVERR);
    wr(8'h28, 32'h155, `BLC_RESP_SLVERR);
    rchk(8'h24, 32'h0, `BLC_RESP_SLVERR);
    for (i = 0; i < 8; i++) rchk(8'(i * 4), rst_val[i], `BLC_RESP_OKAY);
    wr(`BLC_OFS_GAIN, 32'h3FF, `BLC_RESP_OKAY);
    rchk(`BLC_OFS_GAIN, `BLC_GAIN_MAX, `BLC_RESP_OKAY);
    wr(`BLC_OFS_WEIGHT, 32'hF, `BLC_RESP_OKAY);
    rchk(`BLC_OFS_WEIGHT, `BLC_WEIGHT_MAX, `BLC_RESP_OKAY);
    wr(`BLC_OFS_GAIN, 32'h0, `BLC_RESP_OKAY);
    wr(`BLC_OFS_WEIGHT, 32'h0, `BLC_RESP_OKAY);
    for (i = 0; i <= 6; i++) begin
      wr(`BLC_OFS_CTRL, 32'(1 + (i << 2)), `BLC_RESP_OKAY);
      lv = 64 + $random(seed) % 60;
      line(lv, (1 << i) + 8, 1'b0, 1'b0, lv, 64, 0);
    end
    line(100, 40, 1'b0, 1'b0, 0, 64, -1);
    wr(`BLC_OFS_CTRL, 32'h09, `BLC_RESP_OKAY);
    lv = 200 + $random(seed) % 50;
    line(lv, 12, 1'b0, 1'b0, lv, 64, 0);
    wr(`BLC_OFS_HOT, 32'(lv + 5), `BLC_RESP_OKAY);
    wr(`BLC_OFS_COLD, 32'(lv - 5), `BLC_RESP_OKAY);
    line(lv, 12, 1'b1, 1'b0, lv, 64, 0);
    wr(`BLC_OFS_CTRL, 32'h0B, `BLC_RESP_OKAY);
    wr(`BLC_OFS_WEIGHT, 32'h4, `BLC_RESP_OKAY);
    line(lv, 12, 1'b1, 1'b1, (2 * lv + 2046) / 4, 64, 0);
    rchk(`BLC_OFS_STATUS, (2 * lv + 2046) / 4, `BLC_RESP_OKAY);
    wr(`BLC_OFS_CTRL, 32'h09, `BLC_RESP_OKAY);
    wr(`BLC_OFS_WEIGHT, 32'h0, `BLC_RESP_OKAY);
    wr(`BLC_OFS_HOT, 32'h3FF, `BLC_RESP_OKAY);
    wr(`BLC_OFS_COLD, 32'h0, `BLC_RESP_OKAY);
    wr(`BLC_OFS_TARGET, 32'h140, `BLC_RESP_OKAY);
    for (i = 0; i < 8; i++) begin
      wr(`BLC_OFS_GAIN, gains[i], `BLC_RESP_OKAY);
      wr(`BLC_OFS_FINE, 32'h0, `BLC_RESP_OKAY);
      wr(`BLC_OFS_COARSE, 32'h0, `BLC_RESP_OKAY);
      f = 0;
      c = 0;
      line(64, 12, 1'b0, 1'b0, 64, 320, gains[i]);
    end
    wr(`BLC_OFS_CTRL, 32'h08, `BLC_RESP_OKAY);
    wr(`BLC_OFS_FINE, 32'h1F0, `BLC_RESP_OKAY);
    f = -16;
    line(500, 12, 1'b0, 1'b0, 0, 320, -1);
    wr(`BLC_OFS_CTRL, 32'h09, `BLC_RESP_OKAY);
    wr(`BLC_OFS_WEIGHT, 32'h1, `BLC_RESP_OKAY);
    lv = 320 + $random(seed) % 50;
    line(lv, 12, 1'b0, 1'b0, (500 + lv) / 2, 320, 767);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(fine_offset_dac, 32'h0);
    chk(coarse_offset_dac, 32'h0);
    rchk(`BLC_OFS_TARGET, `BLC_RST_TARGET, `BLC_RESP_OKAY);
    results;
  end
endmodule

bind blc_black_level_autocal blc_asserts #(.DW(DW), .AW(AW)) u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .black_clamp_pulse_n, .coarse_offset_dac, .fine_offset_dac
);
